/* logic/otpg_pkg.sv */
// otpg_pkg: constants shared by the otp programmer controller
package otpg_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  // initial pulse 1.0 ms nominal, 0.95..1.05 ms allowed
  localparam int unsigned INIT_PULSE_US = 1000;
  localparam int unsigned INIT_PULSE_CYC = INIT_PULSE_US * (CLK_HZ / 1_000_000);
  // overprogram pulse is 3 ms per initial pulse applied
  localparam int unsigned OVER_UNIT_MS = 3;
  localparam int unsigned OVER_UNIT_PULSES = OVER_UNIT_MS * 1000 / INIT_PULSE_US;
  localparam int unsigned MAX_INIT_PULSES = 25;
  // setup and hold times of 2 us before and after strobes; the overprogram pulse enables data in the same cycle as the strobe
  localparam int unsigned SETUP_US = 2;
  localparam int unsigned SETUP_CYC = SETUP_US * (CLK_HZ / 1_000_000);
  // output gate to data valid is 150 ns max
  localparam int unsigned OE_VALID_NS = 150;
  localparam int unsigned OE_VALID_CYC = (OE_VALID_NS * (CLK_HZ / 1_000_000)
                                          + 999) / 1000;
  localparam int unsigned SIG_BYTE_MFR = 0;
  localparam int unsigned SIG_BYTE_DEV = 1;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
endpackage

/* logic/otpg_timer.sv */
// otpg_timer: down counter that pulses done when a loaded delay ends
`timescale 1ns/1ps
module otpg_timer #(
  parameter int unsigned W = 24
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic load_i,
  input wire logic [W-1:0] count_i,
  output logic done_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
    logic done;
  } otpg_tmr_t;
  otpg_tmr_t r, next_r;

  initial begin
    if (W < 2) $error("otpg_timer width too small");
  end

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (load_i) begin
      next_r.cnt = count_i;
      next_r.run = 1'b1;
    end else if (r.run) begin
      if (r.cnt <= W'(1)) begin
        next_r.run = 1'b0;
        next_r.done = 1'b1;
      end else begin
        next_r.cnt = r.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done_o = r.done;
endmodule

/* logic/otpg_ctrl.sv */
// otpg_ctrl: host controller running the fast program and signature flows
//
// Behaviour
// - each initial program pulse lasts one millisecond
// - overprogram pulse is 3 ms times count
// - at most 25 initial pulses per byte
// - verify after each initial pulse, count pulses
// - after pass, read back and compare all
// - share all lines except select in gangs
// - raise signature line high to identify
// - other address lines low during identification
// - select and strobe low with supply programs
`timescale 1ns/1ps
module otpg_ctrl
  import otpg_pkg::*;
#(
  parameter int unsigned AW = ADDR_W,
  parameter int unsigned MAXP = MAX_INIT_PULSES,
  parameter int unsigned PULSE_CYC = INIT_PULSE_CYC,
  parameter int unsigned GAP_CYC = SETUP_CYC
) (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic PROG_START_I,
  input wire logic SIG_START_I,
  input wire logic [AW-1:0] LAST_ADDR_I,
  output logic [AW-1:0] SRC_ADDR_O,
  input wire logic [7:0] SRC_DATA_I,
  input wire logic [7:0] DATA_I,
  output logic [7:0] DATA_O,
  output logic DATA_OE_O,
  output logic [AW-1:0] ADDR_O,
  output logic CHIP_SEL_N_O,
  output logic OUT_GATE_N_O,
  output logic PROGRAM_STROBE_N_O,
  output logic PROG_SUPPLY_EN_O,
  output logic SIGNATURE_HV_LINE_O,
  output logic BUSY_O,
  output logic DONE_O,
  output logic FAIL_O,
  output logic [AW-1:0] FAIL_ADDR_O,
  output logic [7:0] SIG_MFR_O,
  output logic [7:0] SIG_DEV_O,
  output logic SIG_PARITY_OK_O
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [3:0] {
    S_IDLE, S_SETUP, S_PULSE, S_PGAP, S_VGATE, S_VCHK, S_OVER, S_OGAP,
    S_RSETUP, S_RCHK, S_SSETUP, S_SCHK, S_FIN
  } otpg_state_t;

  localparam int unsigned TW = 24;

  typedef struct packed {
    otpg_state_t st;
    logic [4:0] x;
    logic [AW-1:0] addr;
    logic [7:0] dout;
    logic doe;
    logic cs_n;
    logic oe_n;
    logic pgm_n;
    logic vpp;
    logic hv;
    logic busy;
    logic done;
    logic fail;
    logic [AW-1:0] faddr;
    logic [7:0] mfr;
    logic [7:0] dev;
    logic pok;
    logic tload;
    logic [TW-1:0] tcnt;
  } otpg_regs_t;

  otpg_regs_t r, next_r;
  logic [7:0] din_s1, din_s2;
  logic tdone;

  initial begin
    if (MAXP < 1 || MAXP > 31) $error("otpg_ctrl MAXP out of range");
    if (PULSE_CYC * OVER_UNIT_PULSES * MAXP >= 2 ** TW)
      $error("otpg_ctrl timer too narrow");
  end

  function automatic logic [TW-1:0] cyc(input int unsigned n);
    cyc = TW'(n);
  endfunction

  function automatic logic odd_par(input logic [7:0] b);
    odd_par = ^b;
  endfunction

  otpg_timer #(.W(TW)) u_tmr (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .load_i(r.tload),
    .count_i(r.tcnt),
    .done_o(tdone)
  );

  // pins from the device pass two flops before use
  always_ff @(posedge CLK_I) begin
    din_s1 <= DATA_I;
    din_s2 <= din_s1;
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    next_r = r;
    next_r.tload = 1'b0;
    // done is a strobe: high only in the cycle after the finish state
    next_r.done = 1'b0;
    case (r.st)
      S_IDLE: begin
        next_r.cs_n = 1'b1;
        next_r.oe_n = 1'b1;
        next_r.pgm_n = 1'b1;
        next_r.doe = 1'b0;
        if (PROG_START_I) begin
          next_r = r;
          next_r.tload = 1'b1;
          next_r.tcnt = cyc(GAP_CYC);
          next_r.busy = 1'b1;
          next_r.done = 1'b0;
          next_r.fail = 1'b0;
          next_r.addr = '0;
          next_r.x = '0;
          next_r.vpp = 1'b1;
          next_r.hv = 1'b0;
          next_r.st = S_SETUP;
        end else if (SIG_START_I) begin
          next_r.tload = 1'b1;
          next_r.tcnt = cyc(GAP_CYC);
          next_r.busy = 1'b1;
          next_r.done = 1'b0;
          next_r.addr = AW'(SIG_BYTE_MFR);
          next_r.hv = 1'b1;
          next_r.cs_n = 1'b0;
          next_r.oe_n = 1'b0;
          next_r.st = S_SSETUP;
        end
      end
      S_SETUP: begin
        // select is the only per-device line; gang users fan it out
        next_r.cs_n = 1'b0;
        next_r.oe_n = 1'b1;
        next_r.dout = SRC_DATA_I;
        next_r.doe = 1'b1;
        if (tdone) begin
          next_r.pgm_n = 1'b0;
          next_r.x = r.x + 5'd1;
          next_r.tload = 1'b1;
          next_r.tcnt = cyc(PULSE_CYC);
          next_r.st = S_PULSE;
        end
      end
      S_PULSE: if (tdone) begin
        next_r.pgm_n = 1'b1;
        next_r.tload = 1'b1;
        next_r.tcnt = cyc(GAP_CYC);
        next_r.st = r.x == 5'd0 ? S_OGAP : S_PGAP;
      end
      S_PGAP: if (tdone) begin
        // data hold met, release bus and gate device out in the same cycle
        next_r.doe = 1'b0;
        next_r.oe_n = 1'b0;
        next_r.tload = 1'b1;
        next_r.tcnt = cyc(GAP_CYC);
        next_r.st = S_VGATE;
      end
      S_VGATE: if (tdone) begin
        next_r.st = S_VCHK;
      end
      S_VCHK: begin
        next_r.oe_n = 1'b1;
        next_r.tload = 1'b1;
        next_r.tcnt = cyc(GAP_CYC);
        if (din_s2 == SRC_DATA_I) begin
          next_r.st = S_OVER;
        end else if (r.x >= 5'(MAXP)) begin
          next_r.fail = 1'b1;
          next_r.faddr = r.addr;
          next_r.st = S_FIN;
        end else begin
          next_r.st = S_SETUP;
        end
      end
      S_OVER: if (tdone) begin
        next_r.dout = SRC_DATA_I;
        next_r.doe = 1'b1;
        next_r.pgm_n = 1'b0;
        next_r.tload = 1'b1;
        // 3 ms per initial pulse applied
        next_r.tcnt = cyc(PULSE_CYC * OVER_UNIT_PULSES * r.x);
        next_r.x = '0;
        next_r.st = S_PULSE;
      end
      S_OGAP: if (tdone) begin
        next_r.doe = 1'b0;
        next_r.tload = 1'b1;
        next_r.tcnt = cyc(GAP_CYC);
        if (r.addr == LAST_ADDR_I) begin
          // readback at nominal supply: drop programming level
          next_r.vpp = 1'b0;
          next_r.addr = '0;
          next_r.oe_n = 1'b0;
          next_r.st = S_RSETUP;
        end else begin
          next_r.addr = r.addr + AW'(1);
          next_r.st = S_SETUP;
        end
      end
      S_RSETUP: if (tdone) begin
        next_r.st = S_RCHK;
      end
      S_RCHK: begin
        next_r.tload = 1'b1;
        next_r.tcnt = cyc(GAP_CYC);
        if (din_s2 != SRC_DATA_I) begin
          next_r.fail = 1'b1;
          next_r.faddr = r.addr;
          next_r.st = S_FIN;
        end else if (r.addr == LAST_ADDR_I) begin
          next_r.st = S_FIN;
        end else begin
          next_r.addr = r.addr + AW'(1);
          next_r.st = S_RSETUP;
        end
      end
      S_SSETUP: if (tdone) begin
        next_r.st = S_SCHK;
      end
      S_SCHK: begin
        if (r.addr[0] == 1'b0) begin
          next_r.mfr = din_s2;
          next_r.addr = AW'(SIG_BYTE_DEV);
          next_r.tload = 1'b1;
          next_r.tcnt = cyc(GAP_CYC);
          next_r.st = S_SSETUP;
        end else begin
          next_r.dev = din_s2;
          next_r.pok = odd_par(din_s2) & odd_par(r.mfr);
          next_r.hv = 1'b0;
          next_r.st = S_FIN;
        end
      end
      S_FIN: begin
        next_r.cs_n = 1'b1;
        next_r.oe_n = 1'b1;
        next_r.pgm_n = 1'b1;
        next_r.doe = 1'b0;
        next_r.vpp = 1'b0;
        next_r.hv = 1'b0;
        next_r.addr = '0;
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
        next_r.st = S_IDLE;
      end
      default: next_r.st = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      r <= '0;
      r.st <= S_IDLE;
      r.cs_n <= 1'b1;
      r.oe_n <= 1'b1;
      r.pgm_n <= 1'b1;
      r.dout <= ERASED_BYTE;
    end else begin
      r <= next_r;
    end
  end

  assign SRC_ADDR_O = r.addr;
  assign ADDR_O = r.addr;
  assign DATA_O = r.dout;
  assign DATA_OE_O = r.doe;
  assign CHIP_SEL_N_O = r.cs_n;
  assign OUT_GATE_N_O = r.oe_n;
  assign PROGRAM_STROBE_N_O = r.pgm_n;
  assign PROG_SUPPLY_EN_O = r.vpp;
  assign SIGNATURE_HV_LINE_O = r.hv;
  assign BUSY_O = r.busy;
  assign DONE_O = r.done;
  assign FAIL_O = r.fail;
  assign FAIL_ADDR_O = r.faddr;
  assign SIG_MFR_O = r.mfr;
  assign SIG_DEV_O = r.dev;
  assign SIG_PARITY_OK_O = r.pok;
endmodule

/* tb/otpg_dev_model.sv */
// otpg_dev_model: behavioural one-time-programmable byte memory
`timescale 1ns/1ps
module otpg_dev_model #(
  parameter int unsigned AW = 13,
  parameter logic [7:0] MFR_CODE = 8'h15, // arbitrary odd-parity value
  parameter logic [7:0] DEV_CODE = 8'h8c  // arbitrary odd-parity value
) (
  input wire logic blank_i,
  input wire logic [31:0] need_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] d_i,
  input wire logic cs_n_i,
  input wire logic gate_n_i,
  input wire logic strobe_n_i,
  input wire logic vpp_i,
  input wire logic hv_i,
  output logic [7:0] q_o
);
  // *****
  // cell array
  // *****
  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] last = 8'h00;
  int cnt = 0;
  wire drv = !cs_n_i && !gate_n_i && strobe_n_i;
  wire [7:0] val = hv_i ? (addr_i[0] ? DEV_CODE : MFR_CODE) : mem[addr_i];
  always @(posedge blank_i) begin
    foreach (mem[i]) mem[i] = 8'hff;
    cnt = 0;
  end
  always @(addr_i) cnt = 0;
  // slow cells: a byte takes need_i pulses before it holds zeros
  always @(posedge strobe_n_i) begin
    if (!cs_n_i && vpp_i) begin
      cnt++;
      if (cnt >= need_i) mem[addr_i] &= d_i;
    end
  end
  always @(drv or val) if (drv) last = val;
  // released pins show the inverse, never a stale copy
  assign q_o = drv ? val : ~last;
endmodule

/* tb/otpg_ctrl_sva.sv */
// otpg_ctrl_sva: pin timing checks for the otp programmer controller
`timescale 1ns/1ps
module otpg_ctrl_sva
  import otpg_pkg::*;
#(
  parameter int unsigned AW = ADDR_W,
  parameter int unsigned MAXP = MAX_INIT_PULSES,
  parameter int unsigned PULSE_CYC = INIT_PULSE_CYC
) (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic BUSY_O,
  input wire logic FAIL_O,
  input wire logic DATA_OE_O,
  input wire logic [AW-1:0] ADDR_O,
  input wire logic CHIP_SEL_N_O,
  input wire logic OUT_GATE_N_O,
  input wire logic PROGRAM_STROBE_N_O,
  input wire logic PROG_SUPPLY_EN_O,
  input wire logic SIGNATURE_HV_LINE_O
);
  // *****
  // pulse bookkeeping
  // *****
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  localparam int TOL = PULSE_CYC / 20;
  int low_cnt;
  int x;
  // x counts initial pulses since the last overprogram pulse
  always_ff @(posedge CLK_I) begin
    if (SRST_I || !BUSY_O) begin
      x <= 0;
    end else if ($rose(PROGRAM_STROBE_N_O)) begin
      x <= (low_cnt <= PULSE_CYC + TOL) ? x + 1 : 0;
    end
    low_cnt <= PROGRAM_STROBE_N_O ? 0 : low_cnt + 1;
  end
  sequence s_pulse_end;
    $rose(PROGRAM_STROBE_N_O);
  endsequence
  sequence s_init_len;
    low_cnt >= PULSE_CYC - TOL && low_cnt <= PULSE_CYC + TOL;
  endsequence
  sequence s_over_len;
    x > 0 && low_cnt >= 3 * (PULSE_CYC - TOL) * x
      && low_cnt <= 3 * (PULSE_CYC + TOL) * x;
  endsequence
  a_pulse_len: assert property (s_pulse_end |-> s_init_len or s_over_len)
    else $error("program pulse length wrong");
  a_pulse_limit: assert property (x <= MAXP)
    else $error("too many initial pulses");
  a_strobe_qual: assert property (!PROGRAM_STROBE_N_O |-> !CHIP_SEL_N_O
    && PROG_SUPPLY_EN_O && OUT_GATE_N_O && DATA_OE_O)
    else $error("strobe without program setup");
  a_verify_no_drive: assert property (!OUT_GATE_N_O |-> !DATA_OE_O)
    else $error("data driven while gate low");
  a_sig_addr_low: assert property (SIGNATURE_HV_LINE_O |->
    ADDR_O[AW-1:1] == '0)
    else $error("upper address set in signature mode");
  a_sig_quiet: assert property (SIGNATURE_HV_LINE_O |-> PROGRAM_STROBE_N_O
    && !PROG_SUPPLY_EN_O && !DATA_OE_O)
    else $error("signature mode not a plain read");
  a_fail_idle: assert property (FAIL_O && !BUSY_O |->
    PROGRAM_STROBE_N_O && !PROG_SUPPLY_EN_O)
    else $error("device not stopped after failure");
  a_addr_step: assert property (BUSY_O && !SIGNATURE_HV_LINE_O
    && $changed(ADDR_O) |-> ADDR_O == $past(ADDR_O) + 1'b1 || ADDR_O == '0)
    else $error("address did not ascend");
endmodule
bind otpg_ctrl otpg_ctrl_sva #(.AW(AW), .MAXP(MAXP), .PULSE_CYC(PULSE_CYC)) u_sva (
  .CLK_I(CLK_I), .SRST_I(SRST_I), .BUSY_O(BUSY_O), .FAIL_O(FAIL_O),
  .DATA_OE_O(DATA_OE_O), .ADDR_O(ADDR_O), .CHIP_SEL_N_O(CHIP_SEL_N_O),
  .OUT_GATE_N_O(OUT_GATE_N_O), .PROGRAM_STROBE_N_O(PROGRAM_STROBE_N_O),
  .PROG_SUPPLY_EN_O(PROG_SUPPLY_EN_O),
  .SIGNATURE_HV_LINE_O(SIGNATURE_HV_LINE_O));

/* tb/otpg_ctrl_test.sv */
// otpg_ctrl_test: self-checking bench for the otp programmer controller
`timescale 1ns/1ps
module otpg_ctrl_test;
  import otpg_pkg::*;
  // *****
  // bench
  // *****
  localparam logic [7:0] MFR = 8'h15; // arbitrary odd-parity value
  localparam logic [7:0] DEV = 8'h8c; // arbitrary odd-parity value
  logic clk = 1'b0, srst = 1'b1, prog_go = 1'b0, sig_go = 1'b0, blank = 1'b0;
  logic [12:0] last_addr = '0, src_addr, addr, fail_addr;
  logic [31:0] need = 1;
  logic [7:0] src [0:7];
  logic [7:0] dq, dev_q, data_o, s_mfr, s_dev;
  logic oe, cs_n, gate_n, strobe_n, vpp, hv, busy, done, fail, par_ok;
  logic [17:0] notes [$];
  int num_errors = 0, n_tests = 0, cycles = 0;
  integer seed = 32'h2b53;
  assign dq = oe ? data_o : dev_q;
  otpg_ctrl #(.PULSE_CYC(40), .GAP_CYC(4)) uut (.CLK_I(clk), .SRST_I(srst),
    .PROG_START_I(prog_go), .SIG_START_I(sig_go), .LAST_ADDR_I(last_addr),
    .SRC_ADDR_O(src_addr), .SRC_DATA_I(src[src_addr[2:0]]), .DATA_I(dq),
    .DATA_O(data_o), .DATA_OE_O(oe), .ADDR_O(addr), .CHIP_SEL_N_O(cs_n),
    .OUT_GATE_N_O(gate_n), .PROGRAM_STROBE_N_O(strobe_n),
    .PROG_SUPPLY_EN_O(vpp), .SIGNATURE_HV_LINE_O(hv), .BUSY_O(busy),
    .DONE_O(done), .FAIL_O(fail), .FAIL_ADDR_O(fail_addr),
    .SIG_MFR_O(s_mfr), .SIG_DEV_O(s_dev), .SIG_PARITY_OK_O(par_ok));
  otpg_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) dev (.blank_i(blank),
    .need_i(need), .addr_i(addr), .d_i(dq), .cs_n_i(cs_n), .gate_n_i(gate_n),
    .strobe_n_i(strobe_n), .vpp_i(vpp), .hv_i(hv), .q_o(dev_q));
  initial forever #12.5 clk = ~clk;
  task automatic tally_and_finish();
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  always @(negedge clk) if (done === 1'b1) begin
    check({fail, par_ok, s_mfr, s_dev}, notes.pop_front());
  end
  // a signature start while a program run is busy must be ignored
  task automatic run(input bit is_sig, input logic [17:0] exp);
    @(negedge clk);
    notes.push_back(exp);
    if (is_sig) sig_go = 1'b1;
    else prog_go = 1'b1;
    @(negedge clk);
    sig_go = !is_sig;
    prog_go = 1'b0;
    @(negedge clk);
    sig_go = 1'b0;
    wait (done === 1'b1);
    @(negedge clk);
  endtask
  task automatic new_part(input logic [31:0] n, input logic [12:0] last);
    need = n;
    last_addr = last;
    blank = 1'b1;
    @(negedge clk);
    blank = 1'b0;
  endtask
  task automatic cmp_mem(input int n);
    for (int i = 0; i < n; i++) check({10'h0, dev.mem[i]}, {10'h0, src[i]});
  endtask
  initial begin
    for (int i = 0; i < 8; i++) src[i] = $random(seed);
    @(negedge clk);
    new_part(1, 7);
    repeat (3) @(negedge clk);
    srst = 1'b0;
    run(1, {2'b01, MFR, DEV});
    run(0, {2'b01, MFR, DEV});
    cmp_mem(8);
    new_part(25, 1);
    run(0, {2'b01, MFR, DEV});
    cmp_mem(2);
    new_part(26, 1);
    run(0, {2'b11, MFR, DEV});
    check({5'h0, fail_addr}, 18'h0);
    tally_and_finish();
  end
endmodule
